// [design/atd_pkg.sv]
// Shared constants and types of the task-file command decoder.
// Assumes an APB master with 32-bit data and word-aligned registers.
package atd_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_ERR_FEAT = 6'h01;
  localparam logic [5:0] IDX_SCNT     = 6'h02;
  localparam logic [5:0] IDX_SIDX     = 6'h03;
  localparam logic [5:0] IDX_CYL_LO   = 6'h04;
  localparam logic [5:0] IDX_CYL_HI   = 6'h05;
  localparam logic [5:0] IDX_DHSEL    = 6'h06;
  localparam logic [5:0] IDX_STAT_CMD = 6'h07;
  localparam logic [5:0] IDX_ALT_CTL  = 6'h0E;
  localparam logic [5:0] IDX_DRV_ADDR = 6'h0F;
  localparam logic [5:0] IDX_CFG      = 6'h10;
  // Field positions.
  localparam int DH_LBA = 6;
  localparam int DH_DRV = 4;
  localparam int CTL_SRST = 2;
  localparam int CTL_NIEN = 1;
  // Result and reset values.
  localparam logic [7:0] DIAG_PASS   = 8'h01;
  localparam logic [7:0] DIAG_SLAVE  = 8'h80;
  localparam logic [7:0] ERR_ABORT   = 8'h04;
  localparam logic [7:0] SC_STANDBY  = 8'h00;
  localparam logic [7:0] SC_IDLE     = 8'hFF;
  localparam logic [7:0] DH_ONES     = 8'hA0;
  // Timing.
  localparam int CLK_NS    = 100;
  localparam int BSY_MAX_NS = 400;
  localparam int BSY_MAX_CYC = (BSY_MAX_NS / CLK_NS < 1) ? 1 : BSY_MAX_NS / CLK_NS;
  localparam int DRQ2_US   = 700;
  localparam int DRQ2_CYC  = DRQ2_US * 1000 / CLK_NS;
  localparam int DRQ3_MS   = 20;
  localparam int DRQ3_CYC  = DRQ3_MS * 1000000 / CLK_NS;
  typedef enum logic [3:0] {
    OP_BAD = 4'h0, OP_NOP = 4'h1, OP_CHKPWR = 4'h2, OP_DIAG = 4'h3,
    OP_ERASE = 4'h4, OP_IDLE = 4'h5, OP_STBY = 4'h6, OP_ENG = 4'h7,
    OP_WR2 = 4'h8, OP_WR3 = 4'h9
  } atd_op_t;
  typedef struct packed {
    atd_op_t    op;
    logic       use_head;
  } atd_dec_t;
  // Command handed to the data engine; the eraser gets only its start pulse.
  typedef struct packed {
    logic [7:0]  opcode;
    logic        lba_mode;
    logic        drive;
    logic [3:0]  head;
    logic [7:0]  count;
    logic [7:0]  sector;
    logic [15:0] cyl;
    logic [27:0] lba;
  } atd_cmd_t;
endpackage

// [design/atd_decoder.sv]
// Task-file command acceptance, decode and class timing of a storage card.
// Assumes APB on mclk, a data engine and an eraser on the same clock.
// Notes on behaviour
// - Class 1 raises busy within 400 ns.
// - Class 2: data request within 700 us.
// - Class 3: data request within 20 ms.
// - Write opcodes sorted into classes two, three.
// - Power commands accept both opcode forms.
// - Data transfer opcodes are recognised.
// - Housekeeping opcodes recognised; recalibrate, seek are no-ops.
// - Used parameter registers are taken as valid.
// - Drive-only commands ignore the head field.
// - Check power in standby returns 00h.
// - Check power while idle returns FFh.
// - Card mode diagnostic runs only when addressed.
// - IDE diagnostic ignores drive bit, master combines.
// - Diagnostic result code lands in error register.
// - Erase pre-erases sectors, may report write fault.
// - Drive/head byte has fixed ones, mode, drive.
// - Busy in bit 7 hides other status.
// - Mode flag selects geometry or block address.
// - Primary status read clears interrupt; alternate not.
`timescale 1ns/1ps
`default_nettype none
module atd_decoder import atd_pkg::*; #(
  parameter int DRQ2_LIM = DRQ2_CYC,
  parameter int DRQ3_LIM = DRQ3_CYC
) (
  // Clock and reset.
  input  wire  logic        mclk,
  input  wire  logic        srst,
  // APB slave.
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic              pready,
  output var   logic [31:0] prdata,
  output logic              pslverr,
  // Data engine.
  output var   atd_cmd_t    eng_cmd,
  output var   logic        eng_start,
  input  wire  logic        eng_done,
  input  wire  logic        eng_err,
  input  wire  logic        buf_ready,
  // Eraser.
  output var   logic        erase_start,
  input  wire  logic        erase_done,
  input  wire  logic        erase_fault,
  // Self test and power manager.
  input  wire  logic [7:0]  self_code,
  input  wire  logic        slave_fail,
  input  wire  logic        pwr_transit,
  // Host interrupt.
  output logic              host_irq
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_DECODE = 3'b001, ST_PREP = 3'b010,
    ST_XFER = 3'b011, ST_EXEC = 3'b100, ST_DONE = 3'b101
  } atd_st_t;

  // Opcode table; head use follows whether the command reads the head field.
  function automatic atd_dec_t decode(input logic [7:0] c);
    atd_dec_t d;
    d = '{op: OP_BAD, use_head: 1'b0};
    unique casez (c)
      8'hE5, 8'h98: d.op = OP_CHKPWR;
      8'hE3, 8'h97, 8'hE1, 8'h95: d.op = OP_IDLE;
      8'hE2, 8'h96, 8'hE0, 8'h94, 8'hE6, 8'h99: d.op = OP_STBY;
      8'h90: d.op = OP_DIAG;
      8'hC0: d = '{op: OP_ERASE, use_head: 1'b1};
      8'h20, 8'h21, 8'h40, 8'h41, 8'hC4, 8'hC8, 8'h91, 8'h87, 8'hF5:
        d = '{op: OP_ENG, use_head: 1'b1};
      8'hEC, 8'hE4, 8'hEF, 8'hC6, 8'h03: d.op = OP_ENG;
      8'h00, 8'h1?: d.op = OP_NOP;
      8'h7?: d = '{op: OP_NOP, use_head: 1'b1};
      8'hE8: d.op = OP_WR2;
      8'h30, 8'h31, 8'h38, 8'hCA: d = '{op: OP_WR2, use_head: 1'b1};
      8'hC5, 8'hCD, 8'h3C: d = '{op: OP_WR3, use_head: 1'b1};
      default: d.op = OP_BAD;
    endcase
    return d;
  endfunction

  atd_st_t     st_ff, nxt_st;
  atd_dec_t    dec_ff, nxt_dec;
  logic [7:0]  feat_ff, nxt_feat, err_ff, nxt_err, sc_ff, nxt_sc;
  logic [7:0]  sn_ff, nxt_sn, cmd_ff, nxt_cmd;
  logic [15:0] cyl_ff, nxt_cyl;
  logic [5:0]  dh_ff, nxt_dh;
  logic [1:0]  ctl_ff, nxt_ctl;
  logic [3:0]  cfg_ff, nxt_cfg;
  logic        drq_ff, nxt_drq, errb_ff, nxt_errb, dwf_ff, nxt_dwf;
  logic        irq_ff, nxt_irq, stby_ff, nxt_stby, start_ff, nxt_start;
  logic        ers_ff, nxt_ers;
  logic [17:0] cnt_ff, nxt_cnt;
  logic [31:0] rd_ff, nxt_rd;
  logic        busy, setup, wr, mapped, done_evt, st_rd;
  logic [5:0]  idx;
  logic [7:0]  status, wb;
  atd_cmd_t    cmd_c;

  // Zero-wait slave; read data is captured in the setup cycle.
  assign idx    = paddr[7:2];
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign wb     = pwdata[7:0];
  assign mapped = (idx >= IDX_ERR_FEAT && idx <= IDX_STAT_CMD) || idx == IDX_ALT_CTL ||
                  idx == IDX_DRV_ADDR || idx == IDX_CFG;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rd_ff;
  assign busy = st_ff != ST_IDLE && st_ff != ST_XFER;
  // Other bits are not valid while busy, so they read as zero then.
  assign status = busy ? 8'h80 : {2'b01, dwf_ff, 1'b1, drq_ff, 2'b00, errb_ff};
  assign st_rd = psel && penable && !pwrite && idx == IDX_STAT_CMD;
  assign done_evt = st_ff == ST_DONE;
  assign host_irq = irq_ff && !ctl_ff[0];
  assign eng_start = start_ff;
  assign erase_start = ers_ff;
  assign eng_cmd = cmd_c;

  // Parameter view for the engine; mode flag picks the address form.
  always_comb begin
    cmd_c.opcode   = cmd_ff;
    cmd_c.lba_mode = dh_ff[5];
    cmd_c.drive    = dh_ff[4];
    cmd_c.head     = dec_ff.use_head ? dh_ff[3:0] : 4'h0;
    cmd_c.count    = sc_ff;
    cmd_c.sector   = sn_ff;
    cmd_c.cyl      = cyl_ff;
    cmd_c.lba      = dh_ff[5] ? {dh_ff[3:0], cyl_ff, sn_ff} : 28'h0;
  end

  // Read mux; drive/head reads back with its fixed ones.
  always_comb begin
    nxt_rd = rd_ff;
    if (setup) begin
      nxt_rd = 32'h0;
      unique case (idx)
        IDX_ERR_FEAT: nxt_rd[7:0] = err_ff;
        IDX_SCNT:     nxt_rd[7:0] = sc_ff;
        IDX_SIDX:     nxt_rd[7:0] = sn_ff;
        IDX_CYL_LO:   nxt_rd[7:0] = cyl_ff[7:0];
        IDX_CYL_HI:   nxt_rd[7:0] = cyl_ff[15:8];
        IDX_DHSEL:    nxt_rd[7:0] = DH_ONES | {1'b0, dh_ff[5], 1'b0, dh_ff[4:0]};
        IDX_STAT_CMD, IDX_ALT_CTL: nxt_rd[7:0] = status;
        IDX_DRV_ADDR: nxt_rd[7:0] = {1'b0, !(st_ff == ST_XFER), ~dh_ff[3:0],
                                     !dh_ff[4], dh_ff[4]};
        IDX_CFG:      nxt_rd[3:0] = cfg_ff;
        default:      nxt_rd = 32'h0;
      endcase
    end
  end

  // Host writes, command sequencing and completion.
  always_comb begin
    nxt_st = st_ff;   nxt_dec = dec_ff;  nxt_feat = feat_ff; nxt_err = err_ff;
    nxt_sc = sc_ff;   nxt_sn = sn_ff;    nxt_cyl = cyl_ff;   nxt_dh = dh_ff;
    nxt_cmd = cmd_ff; nxt_ctl = ctl_ff;  nxt_cfg = cfg_ff;   nxt_drq = drq_ff;
    nxt_errb = errb_ff; nxt_dwf = dwf_ff; nxt_stby = stby_ff; nxt_start = 1'b0;
    nxt_ers = 1'b0;   nxt_cnt = cnt_ff;  nxt_irq = irq_ff;
    // Control and configuration stay writable while busy.
    if (wr && idx == IDX_ALT_CTL) nxt_ctl = {wb[CTL_SRST], wb[CTL_NIEN]};
    if (wr && idx == IDX_CFG) nxt_cfg = wb[3:0];
    // Task file is locked while busy; the host may write it when idle or during data transfer.
    if (wr && !busy) begin
      unique case (idx)
        IDX_ERR_FEAT: nxt_feat = wb;
        IDX_SCNT:     nxt_sc = wb;
        IDX_SIDX:     nxt_sn = wb;
        IDX_CYL_LO:   nxt_cyl[7:0] = wb;
        IDX_CYL_HI:   nxt_cyl[15:8] = wb;
        IDX_DHSEL:    nxt_dh = {wb[DH_LBA], wb[DH_DRV], wb[3:0]};
        IDX_STAT_CMD: begin
          nxt_cmd = wb;
          nxt_dec = decode(wb);
          nxt_drq = 1'b0;
          nxt_errb = 1'b0;
          nxt_dwf = 1'b0;
          nxt_st = ST_DECODE;
        end
        default: ;
      endcase
    end
    unique case (st_ff)
      ST_IDLE: ;
      ST_DECODE: begin
        nxt_cnt = 18'h0;
        nxt_st = ST_DONE;
        unique case (dec_ff.op)
          OP_NOP: ;
          OP_IDLE: nxt_stby = 1'b0;
          OP_STBY: nxt_stby = 1'b1;
          // Standby, or on the way in or out, reports zero.
          OP_CHKPWR: nxt_sc = (stby_ff || pwr_transit) ? SC_STANDBY : SC_IDLE;
          OP_DIAG: begin
            // Card mode answers only when its drive number is addressed.
            if (!cfg_ff[0] && dh_ff[4] != cfg_ff[1]) begin
              nxt_st = ST_IDLE;
            end else begin
              nxt_err = self_code;
              if (cfg_ff[0] && !cfg_ff[1] && slave_fail) begin
                nxt_err = DIAG_SLAVE | self_code;
              end
            end
          end
          OP_ERASE: begin
            nxt_ers = 1'b1;
            nxt_st = ST_EXEC;
          end
          OP_ENG: begin
            nxt_start = 1'b1;
            nxt_st = ST_EXEC;
          end
          OP_WR2, OP_WR3: nxt_st = ST_PREP;
          default: begin
            nxt_errb = 1'b1;
            nxt_err = ERR_ABORT;
          end
        endcase
      end
      // Data request rises when the buffer is set up or at the deadline.
      ST_PREP: begin
        nxt_cnt = cnt_ff + 18'h1;
        if (buf_ready || (dec_ff.op == OP_WR2 && 32'(cnt_ff) >= DRQ2_LIM - 2) ||
            32'(cnt_ff) >= DRQ3_LIM - 2) begin
          nxt_drq = 1'b1;
          nxt_start = 1'b1;
          nxt_st = ST_XFER;
        end
      end
      ST_XFER: if (eng_done) begin
        nxt_drq = 1'b0;
        nxt_errb = eng_err;
        nxt_st = ST_DONE;
      end
      ST_EXEC: begin
        if (eng_done && dec_ff.op == OP_ENG) begin
          nxt_errb = eng_err;
          nxt_st = ST_DONE;
        end
        if (erase_done && dec_ff.op == OP_ERASE) begin
          nxt_dwf = erase_fault;
          nxt_errb = erase_fault;
          nxt_st = ST_DONE;
        end
      end
      ST_DONE: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
    // A completion in the same cycle as a status read keeps the interrupt.
    if (st_rd) nxt_irq = 1'b0;
    if (done_evt) nxt_irq = 1'b1;
    // Soft reset ends any command and posts the pass code.
    if (ctl_ff[1]) begin
      nxt_st = ST_IDLE;
      nxt_drq = 1'b0;
      nxt_errb = 1'b0;
      nxt_dwf = 1'b0;
      nxt_err = DIAG_PASS;
      nxt_irq = 1'b0;
    end
  end

  // State registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= ST_IDLE;  dec_ff <= '{op: OP_NOP, use_head: 1'b0};
      feat_ff <= 8'h00;  err_ff <= DIAG_PASS; sc_ff <= 8'h01; sn_ff <= 8'h01;
      cyl_ff <= 16'h0;   dh_ff <= 6'h0;  cmd_ff <= 8'h00;  ctl_ff <= 2'b00;
      cfg_ff <= 4'h0;    drq_ff <= 1'b0; errb_ff <= 1'b0;  dwf_ff <= 1'b0;
      irq_ff <= 1'b0;    stby_ff <= 1'b0; start_ff <= 1'b0; ers_ff <= 1'b0;
      cnt_ff <= 18'h0;   rd_ff <= 32'h0;
    end else begin
      st_ff <= nxt_st;   dec_ff <= nxt_dec;
      feat_ff <= nxt_feat; err_ff <= nxt_err; sc_ff <= nxt_sc; sn_ff <= nxt_sn;
      cyl_ff <= nxt_cyl; dh_ff <= nxt_dh; cmd_ff <= nxt_cmd; ctl_ff <= nxt_ctl;
      cfg_ff <= nxt_cfg; drq_ff <= nxt_drq; errb_ff <= nxt_errb; dwf_ff <= nxt_dwf;
      irq_ff <= nxt_irq; stby_ff <= nxt_stby; start_ff <= nxt_start; ers_ff <= nxt_ers;
      cnt_ff <= nxt_cnt; rd_ff <= nxt_rd;
    end
  end

  // Checks on the command sequencing.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || ctl_ff[1]);
  logic cmd_acc;
  assign cmd_acc = wr && !busy && idx == IDX_STAT_CMD;
  a_busy_rise: assert property (cmd_acc |-> ##[1:4] status[7])
    else $error("busy late after command");
  a_drq2_bound: assert property (st_ff == ST_PREP && dec_ff.op == OP_WR2 |->
    32'(cnt_ff) < DRQ2_LIM)
    else $error("class 2 data request late");
  a_drq3_bound: assert property (st_ff == ST_PREP |-> 32'(cnt_ff) < DRQ3_LIM)
    else $error("class 3 data request late");
  a_busy_drop: assert property ($rose(drq_ff) |-> !status[7])
    else $error("busy kept after data request");
  a_chkpwr_val: assert property (st_ff == ST_DECODE && dec_ff.op == OP_CHKPWR |=>
    sc_ff == (($past(stby_ff) || $past(pwr_transit)) ? SC_STANDBY : SC_IDLE) ##1 irq_ff)
    else $error("check power result wrong");
  a_irq_clear: assert property (st_rd && !done_evt |=> !irq_ff)
    else $error("status read kept interrupt");
  a_abort_err: assert property (st_ff == ST_DECODE && dec_ff.op == OP_BAD |=>
    errb_ff && err_ff == ERR_ABORT && st_ff == ST_DONE)
    else $error("unknown opcode not aborted");
  a_diag_skip: assert property (st_ff == ST_DECODE && dec_ff.op == OP_DIAG && !cfg_ff[0]
    && dh_ff[4] != cfg_ff[1] |=> st_ff == ST_IDLE ##1 !$rose(irq_ff))
    else $error("diagnostic ran on other card");
  a_erase_go: assert property (st_ff == ST_DECODE && dec_ff.op == OP_ERASE |=>
    erase_start && st_ff == ST_EXEC)
    else $error("erase not started");
  a_busy_mask: assert property (status[7] |-> status[6:0] == 7'h0)
    else $error("status bits shown while busy");
  c_write_class2: cover property (st_ff == ST_PREP && dec_ff.op == OP_WR2 ##1 drq_ff);
  c_diag_run: cover property (st_ff == ST_DECODE && dec_ff.op == OP_DIAG ##1 st_ff == ST_DONE);
  c_erase_fault: cover property (st_ff == ST_EXEC && erase_done && erase_fault);
  c_irq_read: cover property (irq_ff && st_rd);
endmodule
`default_nettype wire

// [tb/atd_engine_model.sv]
// Behavioural data engine, eraser and sector buffer behind the decoder.
// Assumes one clock shared with the decoder and a bench that sets delays.
`timescale 1ns/1ps
`default_nettype none
module atd_engine_model (
  // Clock and reset.
  input  wire  logic        mclk,
  input  wire  logic        srst,
  // Decoder side.
  input  wire  logic        eng_start,
  input  wire  logic        erase_start,
  output logic              eng_done,
  output logic              eng_err,
  output logic              buf_ready,
  output logic              erase_done,
  output logic              erase_fault,
  // Bench controls.
  input  wire  logic [15:0] prep_cyc,
  input  wire  logic        fault_on
);
  logic [15:0] prep_ff;
  logic [3:0]  eng_ff;
  logic [3:0]  ers_ff;
  // The buffer refills only up to the asked delay, so a later, longer delay is honoured.
  always_ff @(posedge mclk) begin
    if (srst || eng_start) prep_ff <= 16'h0;
    else if (prep_ff < prep_cyc) prep_ff <= prep_ff + 16'h1;
    eng_ff <= srst ? 4'h0 : eng_start ? 4'h6 : (eng_ff != 4'h0) ? eng_ff - 4'h1 : 4'h0;
    ers_ff <= srst ? 4'h0 : erase_start ? 4'h6 : (ers_ff != 4'h0) ? ers_ff - 4'h1 : 4'h0;
  end
  // Qualifiers show the wrong level outside their done pulse.
  assign buf_ready   = (prep_ff >= prep_cyc);
  assign eng_done    = (eng_ff == 4'h1);
  assign eng_err     = ~eng_done;
  assign erase_done  = (ers_ff == 4'h1);
  assign erase_fault = erase_done ? fault_on : ~fault_on;
endmodule
`default_nettype wire

// [tb/test_ata_command_decoder.sv]
// Self-checking bench of the task-file command decoder.
// Assumes the engine model on the far side and an APB master here.
`timescale 1ns/1ps
`default_nettype none
module test_ata_command_decoder import atd_pkg::*; ;
  // Bench signals; every design input driven by the bench has a value at time zero.
  logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        slave_fail = 0, pwr_transit = 0, fault_on = 0, qerr, saw_drq;
  logic [7:0]  paddr = 0, self_code = 8'h01;
  logic [31:0] pwdata = 0, prdata, q;
  logic [15:0] prep_cyc = 16'h0002;
  logic        pready, pslverr, eng_start, eng_done, eng_err, buf_ready;
  logic        erase_start, erase_done, erase_fault, host_irq;
  atd_cmd_t    eng_cmd;
  int          n_fail = 0, tests_run = 0, n;
  // Clock of 100 ns period.
  always #50 mclk = ~mclk;
  atd_decoder #(.DRQ2_LIM(20), .DRQ3_LIM(40)) uut (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .eng_cmd(eng_cmd), .eng_start(eng_start),
    .eng_done(eng_done), .eng_err(eng_err), .buf_ready(buf_ready), .erase_start(erase_start),
    .erase_done(erase_done), .erase_fault(erase_fault), .self_code(self_code),
    .slave_fail(slave_fail), .pwr_transit(pwr_transit), .host_irq(host_irq));
  atd_engine_model eng (.mclk(mclk), .srst(srst), .eng_start(eng_start),
    .erase_start(erase_start), .eng_done(eng_done), .eng_err(eng_err), .buf_ready(buf_ready),
    .erase_done(erase_done), .erase_fault(erase_fault), .prep_cyc(prep_cyc), .fault_on(fault_on));
  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    qerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Parameters are loaded by callers before the opcode goes in.
  task automatic cmd(input logic [7:0] op);
    apb(1'b1, IDX_STAT_CMD, {24'h0, op});
  endtask
  // Polls the alternate status so a pending interrupt survives; no new command while busy.
  task automatic wait_done();
    saw_drq = 0;
    do begin
      apb(1'b0, IDX_ALT_CTL, 32'h0);
      if (q[3] === 1'b1) saw_drq = 1;
    end while (q[7] !== 1'b0 || q[3] !== 1'b0);
  endtask
  task automatic wait_start();
    n = 0;
    // Sampled just after the edge, so the pulse is seen in the cycle it stands.
    do begin @(posedge mclk); #1; n++; end while (eng_start !== 1'b1 && n < 200);
    if (eng_start !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t start=%h exp=%h", $time, eng_start, 1'b1);
    end
  endtask
  task automatic t_ops();
    logic [7:0] ops [39] = '{8'h00, 8'h10, 8'h1F, 8'h70, 8'h7A, 8'h03, 8'h91, 8'h87, 8'hEF,
      8'hC6, 8'hF5, 8'hE5, 8'h98, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'hE2, 8'h96, 8'hE0, 8'h94,
      8'hE6, 8'h99, 8'h20, 8'h21, 8'h40, 8'h41, 8'hC4, 8'hC8, 8'hEC, 8'hE4, 8'h30, 8'h31,
      8'h38, 8'hE8, 8'hCA, 8'hC5, 8'hCD, 8'h3C};
    foreach (ops[i]) begin
      cmd(ops[i]);
      wait_done();
      chk(q, 32'h50);
      chk({31'h0, saw_drq}, {31'h0, i >= 31});
    end
    apb(1'b0, 6'h3F, 32'h0);
    chk({31'h0, qerr}, 32'h1);
  endtask
  task automatic t_irq();
    apb(1'b0, IDX_STAT_CMD, 32'h0);
    cmd(8'h00);
    n = 0;
    while (host_irq !== 1'b1 && n < 4) begin @(posedge mclk); #1; n++; end
    chk({31'h0, host_irq}, 32'h1);
    apb(1'b0, IDX_ALT_CTL, 32'h0); @(posedge mclk); #1;
    chk({31'h0, host_irq}, 32'h1);
    apb(1'b0, IDX_STAT_CMD, 32'h0); @(posedge mclk); #1;
    chk({31'h0, host_irq}, 32'h0);
  endtask
  task automatic t_power();
    logic [7:0] sb [2] = '{8'hE2, 8'h96}, id [2] = '{8'hE3, 8'h97}, cp [2] = '{8'hE5, 8'h98};
    for (int i = 0; i < 2; i++) begin
      cmd(sb[i]); wait_done(); cmd(cp[i]); wait_done();
      apb(1'b0, IDX_SCNT, 32'h0); chk(q, 32'h00);
      cmd(id[i]); wait_done(); cmd(cp[1 - i]); wait_done();
      apb(1'b0, IDX_SCNT, 32'h0); chk(q, 32'hFF);
    end
    pwr_transit <= 1; cmd(8'hE5); wait_done(); pwr_transit <= 0;
    apb(1'b0, IDX_SCNT, 32'h0); chk(q, 32'h00);
  endtask
  task automatic t_diag();
    apb(1'b1, IDX_CFG, 32'h1); apb(1'b1, IDX_DHSEL, 32'hB0);
    slave_fail <= 1; self_code <= 8'h03;
    cmd(8'h90); wait_done(); apb(1'b0, IDX_ERR_FEAT, 32'h0);
    chk(q, 32'h83);
    apb(1'b0, IDX_STAT_CMD, 32'h0); apb(1'b1, IDX_CFG, 32'h0);
    slave_fail <= 0; self_code <= 8'h01;
    cmd(8'h90); wait_done(); apb(1'b0, IDX_ERR_FEAT, 32'h0);
    chk(q, 32'h83);
    chk({31'h0, host_irq}, 32'h0);
    apb(1'b1, IDX_DHSEL, 32'hA0); cmd(8'h90); wait_done(); apb(1'b0, IDX_ERR_FEAT, 32'h0);
    chk(q, 32'h01);
    cmd(8'h55); wait_done();
    chk(q, 32'h51);
    apb(1'b0, IDX_ERR_FEAT, 32'h0); chk(q, 32'h04);
  endtask
  task automatic t_addr();
    apb(1'b1, IDX_SIDX, 32'h11); apb(1'b1, IDX_CYL_LO, 32'h22); apb(1'b1, IDX_CYL_HI, 32'h33);
    apb(1'b1, IDX_SCNT, 32'h04); apb(1'b1, IDX_DHSEL, 32'h45);
    apb(1'b0, IDX_DHSEL, 32'h0); chk(q, 32'hE5);
    cmd(8'h20); wait_start();
    chk({4'h0, eng_cmd.lba}, 32'h05332211);
    chk({24'h0, eng_cmd.count}, 32'h04);
    chk({30'h0, eng_cmd.lba_mode, eng_cmd.drive}, 32'h2);
    chk({24'h0, eng_cmd.opcode}, 32'h20);
    wait_done();
    apb(1'b1, IDX_DHSEL, 32'h03); cmd(8'h20); wait_start();
    chk({eng_cmd.cyl, 4'h0, eng_cmd.head, eng_cmd.sector}, 32'h33220311);
    chk({4'h0, eng_cmd.lba}, 32'h0);
    wait_done(); cmd(8'hEC); wait_start();
    chk({28'h0, eng_cmd.head}, 32'h0);
    wait_done();
  endtask
  task automatic t_class();
    prep_cyc <= 16'd5000;
    cmd(8'h30);
    apb(1'b0, IDX_ALT_CTL, 32'h0); chk(q, 32'h80);
    wait_start(); chk({31'h0, n <= 21}, 32'h1);
    wait_done(); cmd(8'hC5); wait_start();
    chk({31'h0, n > 21 && n <= 41}, 32'h1);
    wait_done(); prep_cyc <= 16'h0002;
    fault_on <= 1; cmd(8'hC0); wait_done();
    chk(q, 32'h71);
    chk({31'h0, saw_drq}, 32'h0);
    fault_on <= 0; cmd(8'hC0); wait_done(); chk(q, 32'h50);
  endtask
  // Interrupt masking and soft reset through the device control register.
  task automatic t_ctl();
    cmd(8'h55); wait_done();
    apb(1'b1, IDX_ALT_CTL, 32'h02); @(posedge mclk); #1;
    chk({31'h0, host_irq}, 32'h0);
    apb(1'b1, IDX_ALT_CTL, 32'h00); @(posedge mclk); #1;
    chk({31'h0, host_irq}, 32'h1);
    apb(1'b1, IDX_ALT_CTL, 32'h04); apb(1'b1, IDX_ALT_CTL, 32'h00);
    apb(1'b0, IDX_ERR_FEAT, 32'h0); chk(q, 32'h01);
    apb(1'b0, IDX_ALT_CTL, 32'h0); chk(q, 32'h50);
    chk({31'h0, host_irq}, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after a two-cycle reset.
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 0;
    t_ops(); t_irq(); t_power(); t_diag(); t_addr(); t_class(); t_ctl();
    tally_and_finish();
  end
  // Watchdog: far beyond the expected run of under a thousand cycles.
  initial begin
    #(6_000_000);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
